// ---- verif/mpr_regs_assertions.sv ----
// Port checker for the motion-profile parameter register bank.
// Assumes it is bound to mpr_regs and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module mpr_regs_chk #(
  parameter int CNT_W = 28
) (
  // Clock and APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Datapath
  input wire logic [CNT_W-1:0] remaining_pulses,
  input wire logic [15:0] start_speed_working,
  input wire logic [15:0] run_speed_working,
  input wire logic [15:0] auxiliary_speed_reg,
  input wire logic [1:0] speed_sel,
  input wire logic [15:0] accel_rate_working,
  input wire logic [15:0] decel_rate_eff,
  input wire logic [11:0] speed_scale_working,
  input wire logic [23:0] ramp_down_point_working,
  input wire logic [31:0] operation_mode_working,
  input wire logic [27:0] pulse_rate,
  input wire logic decel_start
);
  logic [15:0] spd;
  logic rd;
  assign spd = speed_sel == 2'h1 ? run_speed_working :
               speed_sel == 2'h2 ? auxiliary_speed_reg : start_speed_working;
  assign rd = psel && penable && pready && !pwrite;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_one_wait_state: assert property ($rose(penable) && psel && ce |=> pready)
    else $error("pready not one cycle after access start");
  a_pready_single: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  a_rate_upper_zero: assert property (rd && (paddr inside {8'h00, 8'h04, 8'h20, 8'h24})
    |-> prdata[31:16] == 16'h0000) else $error("rate upper bits not zero");
  a_scale_upper_zero: assert property (rd && (paddr inside {8'h08, 8'h28})
    |-> prdata[31:12] == 20'h00000) else $error("scale upper bits not zero");
  a_mode_fixed_zero: assert property (rd && (paddr inside {8'h10, 8'h30})
    |-> prdata[31:30] == 2'h0 && !prdata[28]) else $error("mode fixed bits not zero");
  a_ramp_upper_read: assert property (rd && paddr == 8'h2C |-> prdata[31:24] ==
    (operation_mode_working[13] ? 8'h00 : {8{prdata[23]}})) else $error("ramp upper bits");
  a_unmapped_error: assert property (pready && psel && paddr[1:0] != 2'h0 |-> pslverr)
    else $error("no error on unaligned address");
  a_decel_fallback: assert property (ce && accel_rate_working != 16'h0000
    |=> decel_rate_eff != 16'h0000) else $error("zero effective deceleration");
  a_pulse_product: assert property (ce |=> pulse_rate ==
    28'($past(speed_scale_working) * $past(spd))) else $error("pulse rate mismatch");
  a_manual_ramp_down: assert property (ce && operation_mode_working[13] |=> decel_start ==
    ($past(remaining_pulses) < CNT_W'($past(ramp_down_point_working))))
    else $error("manual ramp-down start wrong");
  c_read: cover property (rd);
  c_error: cover property (pready && pslverr);
  c_decel: cover property ($rose(decel_start));
endmodule : mpr_regs_chk
bind mpr_regs mpr_regs_chk #(.CNT_W(CNT_W)) chk_u (.pclk, .presetn, .ce, .psel, .penable,
  .pwrite, .paddr, .prdata, .pready, .pslverr, .remaining_pulses, .start_speed_working,
  .run_speed_working, .auxiliary_speed_reg, .speed_sel, .accel_rate_working, .decel_rate_eff,
  .speed_scale_working, .ramp_down_point_working, .operation_mode_working, .pulse_rate,
  .decel_start);
`default_nettype wire

// ---- verif/mpr_regs_test.sv ----
// Self-checking bench for the parameter register bank over APB.
// Assumes the bank answers each transfer with pready while ce is high.
`timescale 1ns/1ps
`default_nettype none
module mpr_regs_test;
  logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, axis_stopped, op_done, ev;
  logic decel_start;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, operation_mode_working, rv;
  logic [27:0] remaining_pulses, auto_decel_point, pulse_rate;
  logic [15:0] start_speed_working, run_speed_working, auxiliary_speed_reg;
  logic [15:0] accel_rate_working, decel_rate_eff;
  logic [1:0] speed_sel;
  logic [11:0] speed_scale_working;
  logic [23:0] ramp_down_point_working;
  logic [31:0] ex [5] = '{32'h0000FFFF, 32'h0000FFFF, 32'h00000FFF, 32'h00FFFFFF, 32'h2FFFFFFF};
  logic [15:0] sp [4] = '{16'h000A, 16'h0014, 16'h001E, 16'h000A};
  logic [23:0] dr [6] = '{24'h000064, 24'h000064, 24'hFFFFF6, 24'hFFFFF6, 24'h00000A, 24'h00000A};
  logic [27:0] dq [6] = '{28'h63, 28'h64, 28'h28, 28'h29, 28'h3C, 28'h3D};
  logic dm [6] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
  logic de [6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
  int error_cnt, tests_run;
  mpr_regs #(.CNT_W(28)) dut_u (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .axis_stopped, .op_done, .remaining_pulses,
    .auto_decel_point, .start_speed_working, .run_speed_working, .auxiliary_speed_reg,
    .speed_sel, .accel_rate_working, .decel_rate_eff, .speed_scale_working,
    .ramp_down_point_working, .operation_mode_working, .pulse_rate, .decel_start);
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  task automatic stop_test;
    $display("Comparisons %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // pready ends the wait; only the watchdog ends one that never sees it.
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rv = prdata;
    ev = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rdc(input logic [7:0] a, input logic [31:0] d, input logic e);
    apb(1'b0, a, 32'h00000000);
    chk(rv, d);
    chk({31'h0, ev}, {31'h0, e});
  endtask : rdc
  task automatic tend(input string s);
    $display("Test %s done, mismatches %0d", s, error_cnt);
  endtask : tend
  initial begin
    #1_000_000;
    error_cnt++;
    stop_test();
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata, axis_stopped, op_done, speed_sel} = '0;
    {ce, remaining_pulses, auto_decel_point} = {1'b1, 28'h0, 28'h32};
    {start_speed_working, run_speed_working, auxiliary_speed_reg} = {sp[0], sp[1], sp[2]};
    presetn = 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 10; i++) rdc(8'(4 * (i % 5) + 32 * (i / 5)), 32'h0, 1'b0);
    tend("reset");
    for (int i = 0; i < 5; i++) apb(1'b1, 8'(4 * i), 32'hFFFFFFFF);
    for (int i = 0; i < 5; i++) rdc(8'(4 * i), ex[i], 1'b0);
    apb(1'b1, 8'h10, 32'h00000000);
    rdc(8'h0C, 32'hFFFFFFFF, 1'b0);
    apb(1'b1, 8'h0C, 32'h007FFFFF);
    rdc(8'h14, 32'h0, 1'b1);
    rdc(8'h02, 32'h0, 1'b1);
    tend("masks");
    chk({16'h0, accel_rate_working}, 32'h0);
    axis_stopped <= 1'b1;
    repeat (3) @(posedge pclk);
    axis_stopped <= 1'b0;
    chk({16'h0, accel_rate_working}, 32'h0000FFFF);
    chk({20'h0, speed_scale_working}, 32'h00000FFF);
    chk({8'h0, ramp_down_point_working}, 32'h007FFFFF);
    rdc(8'h2C, 32'h007FFFFF, 1'b0);
    apb(1'b1, 8'h00, 32'h00001234);
    op_done <= 1'b1;
    @(posedge pclk);
    op_done <= 1'b0;
    apb(1'b1, 8'h24, 32'h00000000);
    repeat (3) @(posedge pclk);
    chk({16'h0, decel_rate_eff}, 32'h00001234);
    apb(1'b1, 8'h24, 32'h00000200);
    repeat (3) @(posedge pclk);
    chk({16'h0, decel_rate_eff}, 32'h00000200);
    tend("transfer");
    apb(1'b1, 8'h28, 32'h00000003);
    for (int i = 0; i < 4; i++) begin
      speed_sel <= 2'(i);
      repeat (3) @(posedge pclk);
      chk({4'h0, pulse_rate}, 32'(sp[i]) * 32'h3);
    end
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, 8'h30, {18'h0, dm[i], 13'h0});
      apb(1'b1, 8'h2C, {8'h0, dr[i]});
      remaining_pulses <= dq[i];
      repeat (3) @(posedge pclk);
      chk({31'h0, decel_start}, {31'h0, de[i]});
    end
    apb(1'b1, 8'h30, 32'hFFFFFFFF);
    @(posedge pclk);
    chk(operation_mode_working, 32'h2FFFFFFF);
    tend("datapath");
    // With ce low the product must hold its old value.
    ce <= 1'b0;
    speed_sel <= 2'h1;
    repeat (3) @(posedge pclk);
    chk({4'h0, pulse_rate}, 32'(sp[3]) * 32'h3);
    ce <= 1'b1;
    repeat (3) @(posedge pclk);
    chk({4'h0, pulse_rate}, 32'(sp[1]) * 32'h3);
    tend("enable");
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    rdc(8'h30, 32'h0, 1'b0);
    chk({16'h0, accel_rate_working}, 32'h0);
    chk({4'h0, pulse_rate}, 32'h0);
    tend("reset again");
    stop_test();
  end
endmodule : mpr_regs_test
`default_nettype wire

// ---- verilog/mpr_params.svh ----
// Constants for the motion-profile parameter register bank.
// Assumes inclusion by bare name from the bank sources only.
`ifndef MPR_PARAMS_SVH
`define MPR_PARAMS_SVH

// Register indices within one bank.
`define MPR_IDX_ACCEL 3'h0
`define MPR_IDX_DECEL 3'h1
`define MPR_IDX_SCALE 3'h2
`define MPR_IDX_RAMP 3'h3
`define MPR_IDX_MODE 3'h4
`define MPR_NUM_REGS 5

// Byte offsets of the pre-register bank and the working bank.
`define MPR_PRE_BASE 8'h00
`define MPR_WORK_BASE 8'h20
`define MPR_BANK_BIT 5
`define MPR_ADDR_HI 7
`define MPR_ADDR_LO 6

// Writable bit masks.
`define MPR_WMASK_RATE 32'h0000_FFFF
`define MPR_WMASK_SCALE 32'h0000_0FFF
`define MPR_WMASK_RAMP 32'h00FF_FFFF
`define MPR_WMASK_MODE 32'h2FFF_FFFF

// Field positions.
`define MPR_MODE_RAMP_MAN_BIT 13
`define MPR_RAMP_SIGN_BIT 23
`define MPR_RAMP_W 24
`define MPR_RATE_W 16
`define MPR_SCALE_W 12

// Reset and fill values.
`define MPR_RESET_VAL 32'h0000_0000
`define MPR_ZERO_RATE 16'h0000

// Speed source selection codes.
`define MPR_SPD_START 2'h0
`define MPR_SPD_RUN 2'h1
`define MPR_SPD_AUX 2'h2

`endif

// ---- verilog/mpr_pkg.sv ----
// Types shared by the motion-profile parameter register bank.
// Assumes nothing of its surroundings.
`default_nettype none
package mpr_pkg;
  typedef enum logic [0:0] {
    MPR_BUS_IDLE,
    MPR_BUS_RESP
  } mpr_bus_state_t;

  typedef logic [31:0] mpr_word_t;
endpackage : mpr_pkg
`default_nettype wire

// ---- verilog/mpr_regs.sv ----
// Motion-profile parameter register bank for one axis, APB slave.
// Assumes axis status, remaining pulse count and speed values come from
// logic on pclk; the host keeps written values inside their ranges.
`timescale 1ns/1ps
`default_nettype none
`include "mpr_params.svh"
// Notes on behaviour
// RULE1: Software loads the acceleration rate with 1 to 65,535 in the low 16 bits.
// RULE2: Bits 31 to 16 of both rate registers drop writes and read as zero.
// RULE3: Sign-extension bits drop writes and read as the top value bit.
// RULE4: Software normally loads the deceleration rate with 1 to 65,535.
// RULE5: A zero deceleration rate means the acceleration rate is used to slow down.
// RULE6: Magnification is 12 bits, loaded with 2 to 4,095, upper bits zero.
// RULE7: Pulse rate equals magnification times the selected speed value.
// RULE8: Ramp-down bits 31 to 24 drop writes and read per mode bit 13.
// RULE9: With mode bit 13 clear the ramp-down value is a signed 24-bit offset.
// RULE10: A positive offset starts slowing earlier, a negative one later.
// RULE11: With mode bit 13 set slowing starts when remaining pulses drop below it.
// RULE12: The mode low half holds the flag bits 15 to 7 and the operation code.
// RULE13: The mode upper half holds bits 29 and 27 to 16, with 31, 30, 28 zero.
// RULE14: Each pre-register has a working register that the operation uses.
// RULE15: All registers clear to zero at reset.
// RULE16: Pre-registers move to working registers when stopped or on completion.
// RULE17: Written values are not range-checked.
module mpr_regs #(
  parameter int CNT_W = 28
) (
  // Clock, reset, clock enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Axis status
  input wire logic axis_stopped,
  input wire logic op_done,
  input wire logic [CNT_W-1:0] remaining_pulses,
  input wire logic [CNT_W-1:0] auto_decel_point,
  // Speed values
  input wire logic [15:0] start_speed_working,
  input wire logic [15:0] run_speed_working,
  input wire logic [15:0] auxiliary_speed_reg,
  input wire logic [1:0] speed_sel,
  // Active parameters
  output logic [15:0] accel_rate_working,
  output logic [15:0] decel_rate_eff,
  output logic [11:0] speed_scale_working,
  output logic [23:0] ramp_down_point_working,
  output logic [31:0] operation_mode_working,
  output logic [27:0] pulse_rate,
  output logic decel_start
);
  if (CNT_W < `MPR_RAMP_W + 1) begin : g_chk
    $error("CNT_W must exceed the ramp-down width");
  end

  mpr_pkg::mpr_word_t pre_r [`MPR_NUM_REGS];
  mpr_pkg::mpr_word_t work_r [`MPR_NUM_REGS];
  mpr_pkg::mpr_bus_state_t bus_state_r;
  mpr_pkg::mpr_word_t prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic pend_r;
  logic [15:0] decel_eff_r;
  logic decel_start_r;
  logic [15:0] spd_mux;
  logic [27:0] rate_w;

  // Address decode.
  logic [2:0] idx;
  logic bank_work;
  logic addr_ok;
  logic wr_go;
  logic xfer;
  assign idx = paddr[4:2];
  assign bank_work = paddr[`MPR_BANK_BIT];
  assign addr_ok = (paddr[`MPR_ADDR_HI:`MPR_ADDR_LO] == 2'h0) && (paddr[1:0] == 2'h0)
                   && (idx < 3'(`MPR_NUM_REGS));
  assign wr_go = ce && psel && penable && pwrite && pready_r && addr_ok;
  // The pending copy fires while stopped, and completion copies whenever ce is high.
  assign xfer = ce && (op_done || (axis_stopped && pend_r)); // RULE16

  // Writable mask per register index.
  function automatic mpr_pkg::mpr_word_t wmask(input logic [2:0] i);
    mpr_pkg::mpr_word_t m;
    m = `MPR_RESET_VAL;
    case (i)
      `MPR_IDX_ACCEL: m = `MPR_WMASK_RATE; // RULE2
      `MPR_IDX_DECEL: m = `MPR_WMASK_RATE; // RULE2
      `MPR_IDX_SCALE: m = `MPR_WMASK_SCALE; // RULE6
      `MPR_IDX_RAMP: m = `MPR_WMASK_RAMP; // RULE8
      `MPR_IDX_MODE: m = `MPR_WMASK_MODE; // RULE13
      default: m = `MPR_RESET_VAL;
    endcase
    return m;
  endfunction : wmask

  // Read view: ramp-down upper byte follows the bank's own mode bit.
  function automatic mpr_pkg::mpr_word_t rview(input logic [2:0] i,
                                               input mpr_pkg::mpr_word_t v,
                                               input logic manual);
    mpr_pkg::mpr_word_t r;
    r = v & wmask(i);
    if (i == `MPR_IDX_RAMP) begin
      if (manual) begin
        r = v & `MPR_WMASK_RAMP; // RULE11
      end else begin
        r = {{8{v[`MPR_RAMP_SIGN_BIT]}}, v[`MPR_RAMP_W-1:0]}; // RULE3 RULE9
      end
    end
    return r;
  endfunction : rview

  // Pre-register and working register storage.
  for (genvar g = 0; g < `MPR_NUM_REGS; g++) begin : g_reg
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        pre_r[g] <= `MPR_RESET_VAL; // RULE15
      end else if (wr_go && !bank_work && (idx == 3'(g))) begin
        pre_r[g] <= pwdata & wmask(3'(g)); // RULE17
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        work_r[g] <= `MPR_RESET_VAL; // RULE15
      end else if (wr_go && bank_work && (idx == 3'(g))) begin
        work_r[g] <= pwdata & wmask(3'(g));
      end else if (xfer) begin
        work_r[g] <= pre_r[g]; // RULE14
      end
    end
  end

  // A pre-register write waits for the axis to stop, or for op_done, before it is copied.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_r <= 1'b0;
    end else if (wr_go && !bank_work) begin
      pend_r <= 1'b1;
    end else if (xfer) begin
      pend_r <= 1'b0;
    end
  end

  // APB response: pready rises one cycle into the access phase.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_state_r <= mpr_pkg::MPR_BUS_IDLE;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else if (ce) begin
      case (bus_state_r)
        mpr_pkg::MPR_BUS_IDLE: begin
          if (psel && penable) begin
            bus_state_r <= mpr_pkg::MPR_BUS_RESP;
            pready_r <= 1'b1;
            pslverr_r <= !addr_ok;
          end
        end
        mpr_pkg::MPR_BUS_RESP: begin
          bus_state_r <= mpr_pkg::MPR_BUS_IDLE;
          pready_r <= 1'b0;
          pslverr_r <= 1'b0;
        end
        default: begin
          bus_state_r <= mpr_pkg::MPR_BUS_IDLE;
          pready_r <= 1'b0;
          pslverr_r <= 1'b0;
        end
      endcase
    end
  end

  // Read data is captured as pready rises and held while it stands.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= `MPR_RESET_VAL;
    end else if (ce && (bus_state_r == mpr_pkg::MPR_BUS_IDLE)) begin
      if (psel && penable && !pwrite && addr_ok) begin
        if (bank_work) begin
          prdata_r <= rview(idx, work_r[idx],
                            work_r[`MPR_IDX_MODE][`MPR_MODE_RAMP_MAN_BIT]); // RULE8
        end else begin
          prdata_r <= rview(idx, pre_r[idx],
                            pre_r[`MPR_IDX_MODE][`MPR_MODE_RAMP_MAN_BIT]); // RULE8
        end
      end else begin
        prdata_r <= `MPR_RESET_VAL;
      end
    end
  end

  // Effective deceleration rate.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      decel_eff_r <= `MPR_ZERO_RATE;
    end else if (ce) begin
      if (work_r[`MPR_IDX_DECEL][`MPR_RATE_W-1:0] == `MPR_ZERO_RATE) begin
        decel_eff_r <= work_r[`MPR_IDX_ACCEL][`MPR_RATE_W-1:0]; // RULE5
      end else begin
        decel_eff_r <= work_r[`MPR_IDX_DECEL][`MPR_RATE_W-1:0];
      end
    end
  end

  // Deceleration start point.
  logic signed [CNT_W+1:0] auto_thr;
  logic signed [CNT_W+1:0] remain_s;
  assign remain_s = $signed({2'b00, remaining_pulses});
  assign auto_thr = $signed({2'b00, auto_decel_point})
                    + (CNT_W+2)'($signed(work_r[`MPR_IDX_RAMP][`MPR_RAMP_W-1:0]));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      decel_start_r <= 1'b0;
    end else if (ce) begin
      if (work_r[`MPR_IDX_MODE][`MPR_MODE_RAMP_MAN_BIT]) begin
        decel_start_r <= remaining_pulses
                         < CNT_W'(work_r[`MPR_IDX_RAMP][`MPR_RAMP_W-1:0]); // RULE11
      end else begin
        decel_start_r <= remain_s <= auto_thr; // RULE10
      end
    end
  end

  // Speed source for the pulse rate product.
  always_comb begin
    spd_mux = start_speed_working;
    case (speed_sel)
      `MPR_SPD_START: spd_mux = start_speed_working;
      `MPR_SPD_RUN: spd_mux = run_speed_working;
      `MPR_SPD_AUX: spd_mux = auxiliary_speed_reg;
      default: spd_mux = start_speed_working;
    endcase
  end

  mpr_speed_scale #(
    .SCALE_W(`MPR_SCALE_W),
    .SPEED_W(`MPR_RATE_W)
  ) u_scale (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .scale(work_r[`MPR_IDX_SCALE][`MPR_SCALE_W-1:0]),
    .speed(spd_mux),
    .rate_r(rate_w)
  );

  // Outputs, all taken from flip-flops.
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign accel_rate_working = work_r[`MPR_IDX_ACCEL][`MPR_RATE_W-1:0];
  assign decel_rate_eff = decel_eff_r;
  assign speed_scale_working = work_r[`MPR_IDX_SCALE][`MPR_SCALE_W-1:0];
  assign ramp_down_point_working = work_r[`MPR_IDX_RAMP][`MPR_RAMP_W-1:0];
  assign operation_mode_working = work_r[`MPR_IDX_MODE]; // RULE12
  assign pulse_rate = rate_w;
  assign decel_start = decel_start_r;
endmodule : mpr_regs
`default_nettype wire

// ---- verilog/mpr_speed_scale.sv ----
// Registered product of speed magnification and a speed register value.
// Assumes inputs come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "mpr_params.svh"
module mpr_speed_scale #(
  parameter int SCALE_W = `MPR_SCALE_W,
  parameter int SPEED_W = `MPR_RATE_W
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // Operands
  input wire logic [SCALE_W-1:0] scale,
  input wire logic [SPEED_W-1:0] speed,
  // Result
  output logic [SCALE_W+SPEED_W-1:0] rate_r
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rate_r <= '0;
    end else if (ce) begin
      rate_r <= scale * speed; // RULE7
    end
  end
endmodule : mpr_speed_scale
`default_nettype wire
